/* File: hdl/ccb_top.sv */
`timescale 1ns/1ps
`include "ccb_cfg.svh"
module ccb_top #(
  parameter int SCAN_AW = 10
) (
  // Clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_ce,
  // Port selection
  input wire ccb_pkg::ccb_strap_t i_port_strap,
  input wire ccb_pkg::ccb_width_t i_bus_width,
  input wire logic i_tap_takeover,
  // Configuration stream
  input wire logic [15:0] i_cfg_data,
  input wire logic i_cfg_valid,
  input wire logic i_tdi_bit,
  input wire logic i_tdi_valid,
  input wire logic i_frame_start,
  input wire logic i_frame_end,
  input wire logic [15:0] i_expected_crc,
  input wire logic i_version_ok,
  input wire logic i_clksel_valid,
  input wire logic [3:0] i_clksel,
  input wire logic i_decrypt_en,
  input wire logic i_new_image,
  input wire logic i_reconfig,
  input wire logic i_io_freeze_update_en,
  // Slave serial pins
  input wire logic i_spi_sck,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_mosi,
  // Soft error scan
  input wire logic i_soft_error_scan_en,
  input wire logic i_soft_error_out_en,
  input wire logic i_soft_error_clr,
  input wire logic [15:0] i_scan_word,
  // Clock outputs
  output logic o_config_master_clock,
  output logic o_user_osc_en,
  // Status
  output logic [4:0] o_port_active,
  output logic o_config_done,
  output logic o_config_error,
  output logic o_crc_error,
  output logic o_load_golden,
  output logic o_io_freeze,
  // Slave serial data out
  output logic o_spi_miso,
  output logic o_spi_miso_oe_n,
  // Soft error scan
  output logic [SCAN_AW-1:0] o_scan_addr,
  output logic o_soft_error
);
  import ccb_pkg::*;

  typedef struct packed {
    ccb_state_t state;
    logic [4:0] port;
    logic [3:0] sel;
    logic sel_seen;
    logic [15:0] crc;
    logic crc_err;
    logic golden;
    logic freeze;
    logic user_en;
    logic err;
    logic sck_q;
    logic [2:0] spi_bits;
    logic [7:0] spi_shift;
    logic [7:0] spi_cmd;
    logic spi_have_cmd;
    logic [7:0] spi_tx;
    logic spi_miso;
    logic spi_oe_n;
    logic [SCAN_AW-1:0] scan_addr;
    logic [15:0] scan_crc;
    logic [15:0] scan_ref;
    logic scan_ref_ok;
    logic seu_flag;
    logic seu_out;
  } ccb_st_t;

  ccb_st_t st_r;
  ccb_st_t st_nxt;
  logic [5:0] half;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] d,
                                           input int n);
    logic [15:0] r;
    logic fb;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      if (i < n) begin
        fb = r[15] ^ d[i];
        r = {r[14:0], 1'b0};
        if (fb) begin
          r = r ^ `CCB_CRC_POLY;
        end
      end
    end
    return r;
  endfunction : crc_step

  function automatic logic [5:0] half_of(input logic [3:0] s);
    logic [5:0] h;
    h = `CCB_HALF_3M1;
    unique case (s)
      4'h0: h = `CCB_HALF_2M5;
      4'h1: h = `CCB_HALF_4M3;
      4'h2: h = `CCB_HALF_5M4;
      4'h3: h = `CCB_HALF_6M9;
      4'h4: h = `CCB_HALF_8M1;
      4'h5: h = `CCB_HALF_9M2;
      4'h6: h = `CCB_HALF_10M;
      4'h7: h = `CCB_HALF_13M;
      4'h8: h = `CCB_HALF_15M;
      4'h9: h = `CCB_HALF_20M;
      4'hA: h = `CCB_HALF_26M;
      4'hB: h = `CCB_HALF_33M;
      default: h = `CCB_HALF_3M1;
    endcase
    return h;
  endfunction : half_of

  // ****************************************
  // Next state
  // ****************************************
  logic spi_rise;
  logic spi_fall;
  logic spi_byte_v;
  logic [7:0] spi_byte;
  logic [4:0] strap_port;
  logic [15:0] wdata;
  int wbits;
  logic wvalid;
  logic crc_ok;
  logic [3:0] sel_lim;
  logic [7:0] status;

  always_comb begin
    st_nxt = st_r;
    spi_rise = i_spi_sck & ~st_r.sck_q;
    spi_fall = ~i_spi_sck & st_r.sck_q;
    spi_byte = {st_r.spi_shift[6:0], i_spi_mosi};
    spi_byte_v = 1'b0;
    status = {st_r.state == CCB_ST_USER, st_r.state == CCB_ST_ERROR, st_r.crc_err,
              st_r.golden, st_r.port[CCB_P_SLAVE_SERIAL], 3'b000};
    st_nxt.sck_q = i_spi_sck;

    // Slave serial port behaves as a serial flash
    if (i_spi_cs_n) begin
      st_nxt.spi_bits = 3'd0;
      st_nxt.spi_have_cmd = 1'b0;
      st_nxt.spi_oe_n = 1'b1;
    end else begin
      if (spi_rise) begin
        st_nxt.spi_shift = spi_byte;
        st_nxt.spi_bits = st_r.spi_bits + 3'd1;
        if (st_r.spi_bits == 3'd7) begin
          st_nxt.spi_tx = status;
          if (!st_r.spi_have_cmd) begin
            st_nxt.spi_cmd = spi_byte;
            st_nxt.spi_have_cmd = 1'b1;
          end else if (st_r.spi_cmd == `CCB_SPI_CMD_WRITE) begin
            spi_byte_v = 1'b1;
          end
        end
      end
      if (spi_fall && st_r.spi_have_cmd &&
          (st_r.spi_cmd == `CCB_SPI_CMD_READ || st_r.spi_cmd == `CCB_SPI_CMD_STATUS)) begin
        st_nxt.spi_oe_n = 1'b0;
        st_nxt.spi_miso = st_r.spi_tx[7];
        st_nxt.spi_tx = {st_r.spi_tx[6:0], 1'b0};
      end
    end

    // Data word from the locked port
    wdata = i_cfg_data;
    wbits = 16;
    wvalid = 1'b0;
    if (st_r.port[CCB_P_TAP]) begin
      wdata = {15'h0000, i_tdi_bit};
      wbits = 1;
      wvalid = i_tdi_valid;
    end else if (st_r.port[CCB_P_SLAVE_SERIAL]) begin
      wdata = {8'h00, spi_byte};
      wbits = 8;
      wvalid = spi_byte_v;
    end else if (st_r.port[CCB_P_CPU] || st_r.port[CCB_P_BOOT_MEM]) begin
      wbits = 8;
      wvalid = i_cfg_valid;
    end else if (st_r.port[CCB_P_PARALLEL]) begin
      wvalid = i_cfg_valid;
      unique case (i_bus_width)
        CCB_W_SERIAL: wbits = 1;
        CCB_W_BYTE: wbits = 8;
        CCB_W_DUAL: wbits = 16;
        default: wbits = 16;
      endcase
    end

    strap_port = 5'b00000;
    unique case (i_port_strap)
      CCB_STRAP_PARALLEL: strap_port[CCB_P_PARALLEL] = 1'b1;
      CCB_STRAP_BOOT_MEM: strap_port[CCB_P_BOOT_MEM] = 1'b1;
      CCB_STRAP_SLAVE_SERIAL: strap_port[CCB_P_SLAVE_SERIAL] = 1'b1;
      CCB_STRAP_CPU: strap_port[CCB_P_CPU] = 1'b1;
    endcase

    sel_lim = i_decrypt_en ? `CCB_SEL_15M : `CCB_SEL_33M;
    crc_ok = (st_r.crc == i_expected_crc);

    // ****************************************
    // Load sequence
    // ****************************************
    unique case (st_r.state)
      CCB_ST_IDLE: begin
        if (i_frame_start) begin
          st_nxt.port = strap_port;
          st_nxt.state = CCB_ST_LOAD;
          st_nxt.crc = `CCB_CRC_INIT;
          st_nxt.sel_seen = 1'b0;
          st_nxt.golden = 1'b0;
        end
      end
      CCB_ST_LOAD: begin
        if (wvalid) begin
          st_nxt.crc = crc_step(st_r.crc, wdata, wbits);
        end
        if (i_frame_start) begin
          st_nxt.crc = `CCB_CRC_INIT;
        end
        if (i_clksel_valid) begin
          st_nxt.sel_seen = 1'b1;
          // Illegal codes fall to the 2.5 MHz code; legal codes clamp by mode
          if (i_clksel > `CCB_SEL_33M) begin
            st_nxt.sel = `CCB_SEL_2M5;
          end else if (i_clksel > sel_lim) begin
            st_nxt.sel = sel_lim;
          end else begin
            st_nxt.sel = i_clksel;
          end
        end
        if (i_frame_end) begin
          if (!st_r.sel_seen) begin
            st_nxt.sel = `CCB_SEL_2M5;
          end
          st_nxt.crc_err = ~crc_ok;
          if (crc_ok && i_version_ok) begin
            st_nxt.state = CCB_ST_USER;
            st_nxt.port = 5'b00000;
            st_nxt.freeze = 1'b0;
          end else if (i_new_image && !st_r.golden) begin
            st_nxt.golden = 1'b1;
            st_nxt.crc = `CCB_CRC_INIT;
            st_nxt.sel_seen = 1'b0;
          end else begin
            st_nxt.state = CCB_ST_ERROR;
            st_nxt.port = 5'b00000;
            st_nxt.freeze = 1'b0;
          end
        end
      end
      CCB_ST_USER: begin
        if (i_reconfig) begin
          st_nxt.state = CCB_ST_LOAD;
          st_nxt.port = strap_port;
          st_nxt.crc = `CCB_CRC_INIT;
          st_nxt.sel_seen = 1'b0;
          st_nxt.golden = 1'b0;
          st_nxt.freeze = i_io_freeze_update_en;
        end
      end
      CCB_ST_ERROR: begin
        if (i_reconfig) begin
          st_nxt.state = CCB_ST_IDLE;
        end
      end
      default: st_nxt.state = CCB_ST_IDLE;
    endcase

    // Boundary-scan takeover overrides any lock
    if (i_tap_takeover) begin
      st_nxt.port = 5'b00000;
      st_nxt.port[CCB_P_TAP] = 1'b1;
      st_nxt.state = CCB_ST_LOAD;
      st_nxt.crc = `CCB_CRC_INIT;
      st_nxt.sel_seen = 1'b0;
      st_nxt.golden = 1'b0;
      if (st_r.state == CCB_ST_USER) begin
        st_nxt.freeze = i_io_freeze_update_en;
      end
    end

    st_nxt.user_en = (st_nxt.state == CCB_ST_USER);
    st_nxt.err = (st_nxt.state == CCB_ST_ERROR);

    // ****************************************
    // Background soft error scan
    // ****************************************
    if (st_r.state == CCB_ST_USER && i_soft_error_scan_en) begin
      st_nxt.scan_addr = st_r.scan_addr + 1'b1;
      st_nxt.scan_crc = crc_step(st_r.scan_crc, i_scan_word, 16);
      if (&st_r.scan_addr) begin
        st_nxt.scan_crc = `CCB_CRC_INIT;
        st_nxt.scan_ref = st_nxt.scan_ref_ok ? st_r.scan_ref :
                          crc_step(st_r.scan_crc, i_scan_word, 16);
        st_nxt.scan_ref_ok = 1'b1;
      end
    end else begin
      st_nxt.scan_addr = '0;
      st_nxt.scan_crc = `CCB_CRC_INIT;
      if (st_r.state != CCB_ST_USER) begin
        st_nxt.scan_ref_ok = 1'b0;
      end
    end
    if (i_soft_error_clr) begin
      st_nxt.seu_flag = 1'b0;
    end
    if (st_r.state == CCB_ST_USER && i_soft_error_scan_en && (&st_r.scan_addr) &&
        st_r.scan_ref_ok && (crc_step(st_r.scan_crc, i_scan_word, 16) != st_r.scan_ref)) begin
      st_nxt.seu_flag = 1'b1;
    end
    st_nxt.seu_out = st_nxt.seu_flag & i_soft_error_out_en;
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      st_r <= '0;
      st_r.state <= CCB_ST_IDLE;
      st_r.sel <= `CCB_SEL_POWERUP;
      st_r.crc <= `CCB_CRC_INIT;
      st_r.spi_oe_n <= 1'b1;
      st_r.scan_crc <= `CCB_CRC_INIT;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // Master clock
  // ****************************************
  assign half = half_of(st_r.sel);

  ccb_clk_div u_div (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_half(half),
    .o_clk(o_config_master_clock)
  );

  assign o_user_osc_en = st_r.user_en;
  assign o_port_active = st_r.port;
  assign o_config_done = st_r.user_en;
  assign o_config_error = st_r.err;
  assign o_crc_error = st_r.crc_err;
  assign o_load_golden = st_r.golden;
  assign o_io_freeze = st_r.freeze;
  assign o_spi_miso = st_r.spi_miso;
  assign o_spi_miso_oe_n = st_r.spi_oe_n;
  assign o_scan_addr = st_r.scan_addr;
  assign o_soft_error = st_r.seu_out;
endmodule : ccb_top

/* File: hdl/ccb_cfg.svh */
`ifndef CCB_CFG_SVH
`define CCB_CFG_SVH
// ****************************************
// Master clock half periods in 200 MHz cycles
// ****************************************
`define CCB_MCLK_MHZ 200
`define CCB_HALF_3M1 6'd32
`define CCB_HALF_2M5 6'd40
`define CCB_HALF_4M3 6'd23
`define CCB_HALF_5M4 6'd19
`define CCB_HALF_6M9 6'd14
`define CCB_HALF_8M1 6'd12
`define CCB_HALF_9M2 6'd11
`define CCB_HALF_10M 6'd10
`define CCB_HALF_13M 6'd8
`define CCB_HALF_15M 6'd7
`define CCB_HALF_20M 6'd5
`define CCB_HALF_26M 6'd4
`define CCB_HALF_33M 6'd3
// ****************************************
// Clock select codes
// ****************************************
`define CCB_SEL_2M5 4'h0
`define CCB_SEL_15M 4'h8
`define CCB_SEL_33M 4'hB
`define CCB_SEL_POWERUP 4'hF
// ****************************************
// Check code and slave serial commands
// ****************************************
`define CCB_CRC_POLY 16'h8005
`define CCB_CRC_INIT 16'hFFFF
`define CCB_SPI_CMD_WRITE 8'h02
`define CCB_SPI_CMD_READ 8'h03
`define CCB_SPI_CMD_STATUS 8'h05
`endif

/* File: hdl/ccb_pkg.sv */
package ccb_pkg;
  typedef enum logic [2:0] {
    CCB_ST_IDLE = 3'b000,
    CCB_ST_LOAD = 3'b001,
    CCB_ST_USER = 3'b010,
    CCB_ST_ERROR = 3'b011
  } ccb_state_t;

  typedef enum logic [1:0] {
    CCB_STRAP_PARALLEL = 2'b00,
    CCB_STRAP_BOOT_MEM = 2'b01,
    CCB_STRAP_SLAVE_SERIAL = 2'b10,
    CCB_STRAP_CPU = 2'b11
  } ccb_strap_t;

  typedef enum logic [1:0] {
    CCB_W_SERIAL = 2'b00,
    CCB_W_BYTE = 2'b01,
    CCB_W_DUAL = 2'b10
  } ccb_width_t;

  // One-hot active port indices
  localparam int CCB_P_PARALLEL = 0;
  localparam int CCB_P_BOOT_MEM = 1;
  localparam int CCB_P_SLAVE_SERIAL = 2;
  localparam int CCB_P_CPU = 3;
  localparam int CCB_P_TAP = 4;
endpackage : ccb_pkg

/* File: hdl/ccb_clk_div.sv */
`timescale 1ns/1ps
`include "ccb_cfg.svh"
module ccb_clk_div (
  // Clock and control
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_ce,
  // Requested half period
  input wire logic [5:0] i_half,
  // Divided clock
  output logic o_clk
);
  typedef struct packed {
    logic [5:0] cnt;
    logic [5:0] half;
    logic clk;
  } ccb_div_st_t;

  ccb_div_st_t st_r;
  ccb_div_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (st_r.cnt >= st_r.half - 6'd1) begin
      // New period only taken at a half boundary, never cutting a pulse
      st_nxt.cnt = 6'd0;
      st_nxt.clk = ~st_r.clk;
      if (st_r.clk) begin
        st_nxt.half = i_half;
      end
    end else begin
      st_nxt.cnt = st_r.cnt + 6'd1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      st_r <= '{cnt: 6'd0, half: `CCB_HALF_3M1, clk: 1'b0};
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  assign o_clk = st_r.clk;
endmodule : ccb_clk_div

/* File: tb/ccb_top_assertions.sv */
`timescale 1ns/1ps
module ccb_top_assertions (
  // Clock and controls
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire ccb_pkg::ccb_strap_t i_port_strap,
  input wire logic i_tap_takeover,
  input wire logic i_frame_start,
  input wire logic i_frame_end,
  input wire logic i_spi_cs_n,
  input wire logic i_soft_error_out_en,
  // Watched outputs
  input wire logic o_config_master_clock,
  input wire logic o_user_osc_en,
  input wire logic [4:0] o_port_active,
  input wire logic o_config_done,
  input wire logic o_config_error,
  input wire logic o_crc_error,
  input wire logic o_spi_miso_oe_n,
  input wire logic o_soft_error
);
  import ccb_pkg::*;
  logic [5:0] run_r;
  logic clk_q_r;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  // ****************************************
  // Cycles since the master clock last moved
  // ****************************************
  always_ff @(posedge i_mclk) begin
    clk_q_r <= o_config_master_clock;
    if (i_reset || o_config_master_clock != clk_q_r) begin
      run_r <= 6'h00;
    end else begin
      run_r <= run_r + {5'h00, i_ce};
    end
  end
  sequence s_high_run;
    o_config_master_clock [*3];
  endsequence
  sequence s_low_run;
    !o_config_master_clock [*3];
  endsequence
  // ****************************************
  // Properties
  // ****************************************
  a_port_onehot: assert property ($onehot0(o_port_active))
    else $error("more than one port active");
  a_port_lock: assert property (o_port_active == 5'h00 && !o_config_done && !o_config_error
    && i_frame_start && i_ce && !i_tap_takeover |=> o_port_active == (5'h01 << $past(i_port_strap)))
    else $error("port not locked from strap");
  a_port_hold: assert property (o_port_active != 5'h00 && i_ce && !i_frame_end
    && !i_tap_takeover |=> o_port_active == $past(o_port_active))
    else $error("active port changed during load");
  a_tap_take: assert property (i_tap_takeover && i_ce |=> o_port_active == 5'h10)
    else $error("scan port did not take over");
  a_full_high: assert property ($rose(o_config_master_clock) |-> s_high_run)
    else $error("short high pulse on master clock");
  a_full_low: assert property ($fell(o_config_master_clock) |-> s_low_run)
    else $error("short low pulse on master clock");
  a_clk_alive: assert property (run_r <= 6'h28)
    else $error("master clock stalled");
  a_user_osc: assert property (o_config_done |-> o_user_osc_en && o_port_active == 5'h00)
    else $error("oscillator not offered in user mode");
  a_done_clean: assert property (o_config_done |-> !o_crc_error && !o_config_error)
    else $error("done with a failed check");
  a_miso_rel: assert property (i_spi_cs_n && i_ce |=> o_spi_miso_oe_n)
    else $error("serial data out driven while deselected");
  a_soft_gate: assert property (o_soft_error |-> $past(i_soft_error_out_en))
    else $error("soft error output while disabled");
endmodule : ccb_top_assertions

/* File: tb/ccb_host_model.sv */
`timescale 1ns/1ps
module ccb_host_model (
  // Clock and command
  input wire logic i_mclk,
  input wire logic i_go,
  input wire logic i_slow,
  input wire logic i_sel_en,
  input wire logic [3:0] i_sel,
  input wire logic i_bad,
  // Stream toward the block
  output logic [15:0] o_data,
  output logic o_valid,
  output logic o_start,
  output logic o_end,
  output logic [15:0] o_crc,
  output logic o_sel_valid,
  output logic [3:0] o_sel,
  output logic o_busy
);
  logic [15:0] crc;
  logic [15:0] w;
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 15; i >= 0; i--) r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? 16'h8005 : 16'h0000);
    return r;
  endfunction : crc_step
  initial begin
    {o_data, o_valid, o_start, o_end, o_crc, o_sel_valid, o_sel, o_busy} = '0;
  end
  // ****************************************
  // One frame: start, four words, select, end
  // ****************************************
  always @(posedge i_mclk) begin
    if (i_go) begin
      crc = 16'hFFFF;
      w = 16'h1234;
      o_busy <= 1'b1;
      o_start <= 1'b1;
      @(posedge i_mclk);
      o_start <= 1'b0;
      for (int k = 0; k < 4; k++) begin
        o_data <= w;
        o_valid <= 1'b1;
        crc = crc_step(crc, w);
        @(posedge i_mclk);
        if (i_slow) begin
          o_valid <= 1'b0;
          o_data <= ~w;
          @(posedge i_mclk);
        end
        w = w + 16'h1111;
      end
      o_valid <= 1'b0;
      o_data <= ~w;
      o_sel_valid <= i_sel_en;
      o_sel <= i_sel;
      @(posedge i_mclk);
      o_sel_valid <= 1'b0;
      o_end <= 1'b1;
      o_crc <= i_bad ? ~crc : crc;
      @(posedge i_mclk);
      o_end <= 1'b0;
      o_crc <= ~o_crc;
      o_busy <= 1'b0;
    end
  end
endmodule : ccb_host_model

/* File: tb/ccb_top_test.sv */
`timescale 1ns/1ps
module ccb_top_test;
  import ccb_pkg::*;
  logic i_mclk = 1'b0, i_reset = 1'b1, i_ce = 1'b1, i_version_ok = 1'b1;
  ccb_strap_t i_port_strap = CCB_STRAP_PARALLEL;
  ccb_width_t i_bus_width = CCB_W_DUAL;
  logic i_tap_takeover = 1'b0, i_tdi_bit = 1'b0, i_tdi_valid = 1'b0, i_decrypt_en = 1'b0;
  logic i_new_image = 1'b0, i_reconfig = 1'b0, i_io_freeze_update_en = 1'b0;
  logic i_spi_sck = 1'b0, i_spi_cs_n = 1'b1, i_spi_mosi = 1'b0, i_soft_error_clr = 1'b0;
  logic i_soft_error_scan_en = 1'b0, i_soft_error_out_en = 1'b0;
  logic [15:0] i_scan_word = 16'h5A5A;
  logic go = 1'b0, slow = 1'b0, sel_en = 1'b0, bad = 1'b0, busy;
  logic [3:0] sel_code = 4'h0;
  logic [3:0] i_clksel;
  logic [15:0] i_cfg_data, i_expected_crc;
  logic i_cfg_valid, i_frame_start, i_frame_end, i_clksel_valid;
  logic o_config_master_clock, o_user_osc_en, o_config_done, o_config_error, o_crc_error;
  logic o_load_golden, o_io_freeze, o_spi_miso, o_spi_miso_oe_n, o_soft_error;
  logic [4:0] o_port_active;
  logic [2:0] o_scan_addr;
  logic [7:0] rx;
  logic [7:0] halves [14] = '{8'h28, 8'h17, 8'h13, 8'h0E, 8'h0C, 8'h0B, 8'h0A, 8'h08, 8'h07,
    8'h05, 8'h04, 8'h03, 8'h28, 8'h07};
  int bad_count = 0, cmp_count = 0, h;
  ccb_top #(.SCAN_AW(3)) ccb_top_i (.i_mclk, .i_reset, .i_ce, .i_port_strap, .i_bus_width,
    .i_tap_takeover, .i_cfg_data, .i_cfg_valid, .i_tdi_bit, .i_tdi_valid, .i_frame_start,
    .i_frame_end, .i_expected_crc, .i_version_ok, .i_clksel_valid, .i_clksel, .i_decrypt_en,
    .i_new_image, .i_reconfig, .i_io_freeze_update_en, .i_spi_sck, .i_spi_cs_n, .i_spi_mosi,
    .i_soft_error_scan_en, .i_soft_error_out_en, .i_soft_error_clr, .i_scan_word,
    .o_config_master_clock, .o_user_osc_en, .o_port_active, .o_config_done, .o_config_error,
    .o_crc_error, .o_load_golden, .o_io_freeze, .o_spi_miso, .o_spi_miso_oe_n, .o_scan_addr,
    .o_soft_error);
  ccb_host_model ccb_host_model_i (.i_mclk(i_mclk), .i_go(go), .i_slow(slow), .i_sel_en(sel_en),
    .i_sel(sel_code), .i_bad(bad), .o_data(i_cfg_data), .o_valid(i_cfg_valid),
    .o_start(i_frame_start), .o_end(i_frame_end), .o_crc(i_expected_crc),
    .o_sel_valid(i_clksel_valid), .o_sel(i_clksel), .o_busy(busy));
  initial forever #2.5 i_mclk = ~i_mclk;
  initial begin
    #500_000;
    hang();
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  task automatic hang;
    bad_count++;
    $display("[FAIL] %0t wait limit used up", $time);
    test_done();
  endtask : hang
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_mck(input logic v);
    int n;
    for (n = 0; n < 100 && o_config_master_clock !== v; n++) @(negedge i_mclk);
    if (n == 100) hang();
  endtask : wait_mck
  task automatic meas(output int len);
    wait_mck(1'b1);
    wait_mck(1'b0);
    wait_mck(1'b1);
    for (len = 0; len < 100 && o_config_master_clock === 1'b1; len++) @(negedge i_mclk);
  endtask : meas
  task automatic frame(input logic [3:0] code, input logic use_sel, input logic corrupt);
    int n;
    @(posedge i_mclk);
    sel_code <= code;
    sel_en <= use_sel;
    bad <= corrupt;
    go <= 1'b1;
    @(posedge i_mclk);
    go <= 1'b0;
    repeat (2) @(negedge i_mclk);
    check(o_port_active, 5'h01);
    for (n = 0; n < 300 && busy !== 1'b0; n++) @(negedge i_mclk);
    if (n == 300) hang();
  endtask : frame
  task automatic restart(input logic img);
    @(posedge i_mclk);
    i_reconfig <= 1'b1;
    i_new_image <= img;
    i_io_freeze_update_en <= 1'b1;
    @(posedge i_mclk);
    i_reconfig <= 1'b0;
    @(negedge i_mclk);
  endtask : restart
  task automatic spi_byte(input logic [7:0] tx, output logic [7:0] got);
    for (int b = 7; b >= 0; b--) begin
      @(posedge i_mclk);
      i_spi_mosi <= tx[b];
      i_spi_sck <= 1'b0;
      repeat (3) @(posedge i_mclk);
      i_spi_sck <= 1'b1;
      got[b] = o_spi_miso;
      repeat (3) @(posedge i_mclk);
    end
  endtask : spi_byte
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (6) @(posedge i_mclk);
    i_reset <= 1'b0;
    meas(h);
    check(16'(h), 16'h0020);
    frame(4'h0, 1'b0, 1'b0);
    check({o_config_done, o_user_osc_en, o_crc_error}, 3'h6);
    meas(h);
    check(16'(h), 16'h0028);
    for (int i = 0; i < 14; i++) begin
      @(posedge i_mclk);
      i_decrypt_en <= (i == 13);
      slow <= i[0];
      restart(1'b0);
      check(o_io_freeze, 1'b1);
      frame((i == 13) ? 4'hB : i[3:0], 1'b1, 1'b0);
      check({o_config_done, o_io_freeze}, 2'h2);
      meas(h);
      check(16'(h), {8'h00, halves[i]});
    end
    @(posedge i_mclk);
    i_spi_cs_n <= 1'b0;
    spi_byte(8'h05, rx);
    spi_byte(8'h00, rx);
    check({rx, o_spi_miso_oe_n}, 9'h100);
    @(posedge i_mclk);
    i_spi_cs_n <= 1'b1;
    i_soft_error_scan_en <= 1'b1;
    i_soft_error_out_en <= 1'b1;
    repeat (30) @(negedge i_mclk);
    check(o_soft_error, 1'b0);
    check(o_scan_addr, 3'h5);
    @(posedge i_mclk);
    i_scan_word <= 16'hA5A5;
    repeat (30) @(negedge i_mclk);
    check(o_soft_error, 1'b1);
    @(posedge i_mclk);
    i_soft_error_scan_en <= 1'b0;
    i_soft_error_out_en <= 1'b0;
    i_soft_error_clr <= 1'b1;
    @(posedge i_mclk);
    i_soft_error_clr <= 1'b0;
    restart(1'b1);
    frame(4'h0, 1'b0, 1'b1);
    check({o_load_golden, o_crc_error, o_config_done}, 3'h6);
    frame(4'h0, 1'b0, 1'b0);
    check({o_config_done, o_crc_error}, 2'h2);
    restart(1'b0);
    frame(4'h0, 1'b0, 1'b1);
    check({o_config_error, o_crc_error, o_config_done}, 3'h6);
    restart(1'b0);
    check({o_config_error, o_port_active}, 6'h00);
    @(posedge i_mclk);
    i_tap_takeover <= 1'b1;
    @(posedge i_mclk);
    i_tap_takeover <= 1'b0;
    i_tdi_valid <= 1'b1;
    i_tdi_bit <= 1'b1;
    @(posedge i_mclk);
    i_tdi_valid <= 1'b0;
    @(negedge i_mclk);
    check(o_port_active, 5'h10);
    @(posedge i_mclk);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_reset <= 1'b0;
    @(negedge i_mclk);
    check({o_port_active, o_spi_miso_oe_n, o_config_done}, 7'h02);
    meas(h);
    check(16'(h), 16'h0020);
    test_done();
  end
endmodule : ccb_top_test
bind ccb_top ccb_top_assertions ccb_top_assertions_i (.i_mclk, .i_reset, .i_ce, .i_port_strap,
  .i_tap_takeover, .i_frame_start, .i_frame_end, .i_spi_cs_n, .i_soft_error_out_en,
  .o_config_master_clock, .o_user_osc_en, .o_port_active, .o_config_done, .o_config_error,
  .o_crc_error, .o_spi_miso_oe_n, .o_soft_error);
